// [rmb_cfg.svh]
// constants of the radio modem link parameter bank
`ifndef RMB_CFG_SVH
`define RMB_CFG_SVH
// command codes
`define RMB_CMD_WAKE_IDLE    8'h03
`define RMB_CMD_SOFT_FLOW    8'h07
`define RMB_CMD_WAKE_DUR     8'h0C
`define RMB_CMD_GOOD_CNT     8'h10
`define RMB_CMD_HOP_CHAN     8'h11
`define RMB_CMD_FLOW_THR     8'h24
`define RMB_CMD_VENDOR_ID    8'h27
`define RMB_CMD_CIPHER_KEY   8'h3C
`define RMB_CMD_FORCE_SYNC   8'h3E
`define RMB_CMD_HW_VERSION   8'h7E
// reset values and limits
`define RMB_RST_WAKE_IDLE    16'hFFFF
`define RMB_WAKE_IDLE_OFF    16'hFFFF
`define RMB_RST_SOFT_FLOW    1'b0
`define RMB_RST_WAKE_DUR     8'h01
`define RMB_RST_GOOD_CNT     16'h0000
`define RMB_GOOD_CNT_MAX     16'hFFFF
`define RMB_RST_HOP_CHAN     4'h0
`define RMB_HOP_CHAN_MAX     4'h9
`define RMB_RST_FORCE_SYNC   16'h0000
`define RMB_RX_BUF_SIZE      12'h800
`define RMB_FLOW_MARGIN      12'h011
`define RMB_VID_USER_MIN     16'h0011
`define RMB_VID_USER_MAX     16'h7FFF
// flow characters
`define RMB_XON_CHAR         8'h11
`define RMB_XOFF_CHAR        8'h13
// key sizes in hex digits, IV size in bytes
`define RMB_KEY_DIGITS_FULL  7'h40
`define RMB_KEY_DIGITS_INTL  7'h20
`define RMB_IV_BYTES         8'h10
// timing
`define RMB_CLK_HZ           20000000
`define RMB_TICK_MS          10
`define RMB_LONG_TICK_MS     100
`define RMB_WAKE_DET_MS      35
`define RMB_TICK_CYC         ((`RMB_CLK_HZ / 1000) * `RMB_TICK_MS)
`define RMB_LONG_DIV         (`RMB_LONG_TICK_MS / `RMB_TICK_MS)
`define RMB_WAKE_DET_CYC     ((`RMB_CLK_HZ / 1000) * `RMB_WAKE_DET_MS)
`endif

// [rmb_pkg.sv]
// types of the radio modem link parameter bank
package rmb_pkg;
   typedef enum logic [0:0] {
      FLW_RUN   = 1'b0,
      FLW_PAUSE = 1'b1
   } rmb_flow_e;
   typedef enum logic [0:0] {
      WK_IDLE = 1'b0,
      WK_SEND = 1'b1
   } rmb_wake_e;
   typedef logic [15:0] rmb_word_t;
endpackage : rmb_pkg

// [rmb_param_bank.sv]
// radio modem link parameter bank: flow control, sync, counters, filters, key, wake-up
//
// Notes on behaviour
// - one-bit software flow enable, reset disabled.
// - resume character 0x11, pause character 0x13.
// - general output one acts as clear-to-send; host sends only while permitted.
// - at threshold fill, drop clear-to-send, or send pause when software flow on.
// - threshold 0 to buffer size minus 0x11, that is the default, two bytes.
// - only first packet of a stream carries the full initializer.
// - nonzero forced sync time, 10 ms units, periodically forces full initializer.
// - buffer drained and radio paused forces full initializer next transmission.
// - writable volatile good packet counter, zero at reset, two bytes.
// - good packet counter saturates at 0xFFFF until written or reset.
// - sleep states never clear the good packet counter.
// - hop channel 0 to 9, default 0; only equal channels exchange data.
// - idle time in 100 ms before wake-up initializer; 0xFFFF disables.
// - cyclic sleeper wakes each interval; on initializer stays awake.
// - 16-bit vendor id filter; user values 0x11 to 0x7FFF only.
// - 256-bit key, write only, zero disables encryption.
// - encrypted payload in CBC, CRC over ciphertext, 16-byte IV appended.
// - key accepts zero or full 64 hex digits, else error.
// - international variant uses a 128-bit key, same behaviour.
// - wake-up initializer lasts 0 to 0xFF units of 100 ms, default 1.
// - sleeper stays awake only after about 35 ms of continuous initializer.
`timescale 1ns/1ps
`default_nettype none
`include "rmb_cfg.svh"

module rmb_param_bank
   import rmb_pkg::*;
#(
   parameter int TICK_CYC     = `RMB_TICK_CYC,
   parameter int WAKE_DET_CYC = `RMB_WAKE_DET_CYC,
   parameter logic [15:0] HW_VERSION = 16'h0A5C, // arbitrary value
   parameter logic [15:0] VENDOR_RST = 16'h1234  // arbitrary value
) (
   // clock and reset
   input  wire logic          i_sys_clk,
   input  wire logic          i_arst_n,
   // command port
   input  wire logic          i_cmd_valid,
   input  wire logic          i_cmd_write,
   input  wire logic [7:0]    i_cmd_code,
   input  wire logic [15:0]   i_cmd_wdata,
   input  wire logic [255:0]  i_key_wdata,
   input  wire logic [6:0]    i_key_digits,
   input  wire logic          i_intl_variant,
   output logic               o_rsp_valid,
   output logic               o_rsp_error,
   output logic [15:0]        o_rsp_data,
   output logic [1:0]         o_rsp_nbytes,
   // host serial flow control
   input  wire logic [11:0]   i_rx_fill,
   input  wire logic          i_host_tx_ready,
   output logic               o_general_output_one_n,
   output logic               o_host_tx_valid,
   output logic [7:0]         o_host_tx_char,
   // radio transmit side
   input  wire logic          i_tx_pkt_start,
   input  wire logic          i_radio_tx_busy,
   input  wire logic          i_stream_active,
   input  wire logic          i_serial_activity,
   input  wire logic          i_radio_activity,
   output logic               o_tx_full_init,
   output logic               o_wake_init_tx,
   // radio receive side
   input  wire logic          i_rx_hdr_valid,
   input  wire logic [3:0]    i_rx_hop_channel,
   input  wire logic [15:0]   i_rx_vendor_id,
   input  wire logic          i_good_pkt,
   output logic               o_rx_accept,
   output logic [3:0]         o_hop_channel,
   // cyclic sleep receive
   input  wire logic          i_cyclic_sleep,
   input  wire logic          i_sleep_interval_tick,
   input  wire logic          i_wake_init_detect,
   input  wire logic          i_rx_done,
   output logic               o_rx_listen,
   output logic               o_stay_awake,
   // cipher engine
   output logic               o_encrypt_en,
   output logic [255:0]       o_cipher_key,
   output logic [7:0]         o_iv_bytes
);

   // =========================================================
   // command decode
   localparam logic [11:0] THR_MAX = `RMB_RX_BUF_SIZE - `RMB_FLOW_MARGIN;

   logic [15:0]  wake_idle_time_reg;
   logic         soft_flow_enable_reg;
   logic [7:0]   wake_init_duration_reg;
   logic [15:0]  good_packet_count_reg;
   logic [3:0]   hop_channel_reg;
   logic [11:0]  flow_threshold_reg;
   logic [15:0]  vendor_filter_id_reg;
   logic [255:0] cipher_key_reg;
   logic [15:0]  forced_sync_time_reg;

   wire wr = i_cmd_valid & i_cmd_write;
   wire hit_idle = (i_cmd_code == `RMB_CMD_WAKE_IDLE);
   wire hit_flow = (i_cmd_code == `RMB_CMD_SOFT_FLOW);
   wire hit_dur  = (i_cmd_code == `RMB_CMD_WAKE_DUR);
   wire hit_good = (i_cmd_code == `RMB_CMD_GOOD_CNT);
   wire hit_hop  = (i_cmd_code == `RMB_CMD_HOP_CHAN);
   wire hit_thr  = (i_cmd_code == `RMB_CMD_FLOW_THR);
   wire hit_vid  = (i_cmd_code == `RMB_CMD_VENDOR_ID);
   wire hit_key  = (i_cmd_code == `RMB_CMD_CIPHER_KEY);
   wire hit_fs   = (i_cmd_code == `RMB_CMD_FORCE_SYNC);
   wire hit_hv   = (i_cmd_code == `RMB_CMD_HW_VERSION);
   wire hit_any  = hit_idle | hit_flow | hit_dur | hit_good | hit_hop
                 | hit_thr | hit_vid | hit_key | hit_fs | hit_hv;

   wire ok_flow = (i_cmd_wdata[15:1] == 15'h0000);
   wire ok_dur  = (i_cmd_wdata[15:8] == 8'h00);
   wire ok_hop  = (i_cmd_wdata <= {12'h000, `RMB_HOP_CHAN_MAX});
   wire ok_thr  = (i_cmd_wdata <= {4'h0, THR_MAX});
   wire ok_vid  = (i_cmd_wdata >= `RMB_VID_USER_MIN) &&
                  (i_cmd_wdata <= `RMB_VID_USER_MAX);
   wire [6:0] key_full = i_intl_variant ? `RMB_KEY_DIGITS_INTL
                                        : `RMB_KEY_DIGITS_FULL;
   wire key_zero = (i_key_wdata == 256'h0);
   wire key_fits = i_intl_variant ? (i_key_wdata[255:128] == 128'h0) : 1'b1;
   wire ok_key   = (i_key_digits != 7'h00) &&
                   (key_zero || ((i_key_digits == key_full) && key_fits));

   wire wr_err = ~hit_any | hit_hv
               | (hit_flow & ~ok_flow) | (hit_dur & ~ok_dur)
               | (hit_hop & ~ok_hop) | (hit_thr & ~ok_thr)
               | (hit_vid & ~ok_vid) | (hit_key & ~ok_key);
   wire rd_err = ~hit_any | hit_key;
   wire cmd_err = i_cmd_write ? wr_err : rd_err;
   wire do_wr = wr & ~wr_err;

   wire [15:0] rd_data =
        hit_idle ? wake_idle_time_reg :
        hit_flow ? {15'h0000, soft_flow_enable_reg} :
        hit_dur  ? {8'h00, wake_init_duration_reg} :
        hit_good ? good_packet_count_reg :
        hit_hop  ? {12'h000, hop_channel_reg} :
        hit_thr  ? {4'h0, flow_threshold_reg} :
        hit_vid  ? vendor_filter_id_reg :
        hit_fs   ? forced_sync_time_reg :
        hit_hv   ? HW_VERSION : 16'h0000;
   // two-byte answers for the wide parameters
   wire two_b = hit_idle | hit_good | hit_thr | hit_vid | hit_fs | hit_hv | hit_key;
   wire [1:0] rd_nb = cmd_err ? 2'h0 : (two_b ? 2'h2 : 2'h1);

   // =========================================================
   // response
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rsp_valid  <= 1'b0;
         o_rsp_error  <= 1'b0;
         o_rsp_data   <= 16'h0000;
         o_rsp_nbytes <= 2'h0;
      end else begin
         o_rsp_valid  <= i_cmd_valid;
         o_rsp_error  <= i_cmd_valid & cmd_err;
         o_rsp_data   <= (i_cmd_valid & ~i_cmd_write & ~cmd_err) ? rd_data : 16'h0000;
         o_rsp_nbytes <= (i_cmd_valid & ~i_cmd_write) ? rd_nb : 2'h0;
      end
   end

   // =========================================================
   // parameter registers
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wake_idle_time_reg     <= `RMB_RST_WAKE_IDLE;
         soft_flow_enable_reg   <= `RMB_RST_SOFT_FLOW;
         wake_init_duration_reg <= `RMB_RST_WAKE_DUR;
         hop_channel_reg        <= `RMB_RST_HOP_CHAN;
         flow_threshold_reg     <= THR_MAX;
         vendor_filter_id_reg   <= VENDOR_RST;
         cipher_key_reg         <= 256'h0;
         forced_sync_time_reg   <= `RMB_RST_FORCE_SYNC;
      end else if (do_wr) begin
         if (hit_idle) wake_idle_time_reg     <= i_cmd_wdata;
         if (hit_flow) soft_flow_enable_reg   <= i_cmd_wdata[0];
         if (hit_dur)  wake_init_duration_reg <= i_cmd_wdata[7:0];
         if (hit_hop)  hop_channel_reg        <= i_cmd_wdata[3:0];
         if (hit_thr)  flow_threshold_reg     <= i_cmd_wdata[11:0];
         if (hit_vid)  vendor_filter_id_reg   <= i_cmd_wdata;
         if (hit_key)  cipher_key_reg         <= i_key_wdata;
         if (hit_fs)   forced_sync_time_reg   <= i_cmd_wdata;
      end
   end

   // good packet counter, write wins, saturating
   wire [15:0] good_next = (good_packet_count_reg == `RMB_GOOD_CNT_MAX) ?
                           good_packet_count_reg : good_packet_count_reg + 16'h0001;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n)            good_packet_count_reg <= `RMB_RST_GOOD_CNT;
      else if (do_wr & hit_good) good_packet_count_reg <= i_cmd_wdata;
      else if (i_good_pkt)      good_packet_count_reg <= good_next;
   end

   // =========================================================
   // time base: 10 ms tick and 100 ms tick
   logic [31:0] tick_cnt_reg;
   logic [3:0]  long_cnt_reg;
   wire tick10  = (tick_cnt_reg == 32'(TICK_CYC - 1));
   wire tick100 = tick10 & (long_cnt_reg == 4'(`RMB_LONG_DIV - 1));
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tick_cnt_reg <= 32'h0;
         long_cnt_reg <= 4'h0;
      end else begin
         tick_cnt_reg <= tick10 ? 32'h0 : tick_cnt_reg + 32'h1;
         if (tick100)     long_cnt_reg <= 4'h0;
         else if (tick10) long_cnt_reg <= long_cnt_reg + 4'h1;
      end
   end

   // =========================================================
   // host flow control
   rmb_flow_e flow_reg;
   wire at_thr = (i_rx_fill >= flow_threshold_reg);
   // pause when high, resume once below
   wire send_xoff = soft_flow_enable_reg & (flow_reg == FLW_RUN) & at_thr & i_host_tx_ready;
   wire send_xon  = (flow_reg == FLW_PAUSE) & ~at_thr & i_host_tx_ready;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flow_reg               <= FLW_RUN;
         o_host_tx_valid        <= 1'b0;
         o_host_tx_char         <= 8'h00;
         o_general_output_one_n <= 1'b0;
      end else begin
         if (send_xoff)     flow_reg <= FLW_PAUSE;
         else if (send_xon) flow_reg <= FLW_RUN;
         o_host_tx_valid <= send_xoff | send_xon;
         o_host_tx_char  <= send_xoff ? `RMB_XOFF_CHAR :
                            send_xon  ? `RMB_XON_CHAR  : 8'h00;
         // clear-to-send drops only with software flow off
         o_general_output_one_n <= at_thr & ~soft_flow_enable_reg;
      end
   end

   // =========================================================
   // full initializer scheduling
   logic [15:0] fs_cnt_reg;
   wire fs_hit = (forced_sync_time_reg != 16'h0000) & i_stream_active & tick10 &
                 (fs_cnt_reg >= forced_sync_time_reg - 16'h0001);
   wire gap_set = (i_rx_fill == 12'h000) & ~i_radio_tx_busy & ~i_tx_pkt_start;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fs_cnt_reg     <= 16'h0000;
         o_tx_full_init <= 1'b1;
      end else begin
         if (fs_hit | ~i_stream_active) fs_cnt_reg <= 16'h0000;
         else if (tick10)               fs_cnt_reg <= fs_cnt_reg + 16'h0001;
         // cleared by a packet, set wins over the clear
         if (fs_hit | gap_set)    o_tx_full_init <= 1'b1;
         else if (i_tx_pkt_start) o_tx_full_init <= 1'b0;
      end
   end

   // =========================================================
   // wake-up initializer on transmit
   rmb_wake_e   wake_reg;
   logic [15:0] idle_cnt_reg;
   logic [7:0]  dur_cnt_reg;
   wire activity = i_serial_activity | i_radio_activity;
   // idle time elapsed and not disabled
   wire wake_due = (wake_idle_time_reg != `RMB_WAKE_IDLE_OFF) &
                   (idle_cnt_reg >= wake_idle_time_reg);
   // send for the configured duration, zero means none
   wire wake_go  = (wake_reg == WK_IDLE) & i_tx_pkt_start & wake_due &
                   (wake_init_duration_reg != 8'h00);
   wire wake_end = (wake_reg == WK_SEND) & tick100 &
                   (dur_cnt_reg == wake_init_duration_reg - 8'h01);
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         idle_cnt_reg <= 16'h0000;
      end else if (activity) begin
         idle_cnt_reg <= 16'h0000;
      end else if (tick100 && idle_cnt_reg != 16'hFFFF) begin
         idle_cnt_reg <= idle_cnt_reg + 16'h0001;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wake_reg       <= WK_IDLE;
         dur_cnt_reg    <= 8'h00;
         o_wake_init_tx <= 1'b0;
      end else begin
         unique case (wake_reg)
            WK_IDLE: begin
               dur_cnt_reg <= 8'h00;
               if (wake_go) wake_reg <= WK_SEND;
            end
            WK_SEND: begin
               if (wake_end)     wake_reg    <= WK_IDLE;
               else if (tick100) dur_cnt_reg <= dur_cnt_reg + 8'h01;
            end
         endcase
         o_wake_init_tx <= wake_go | ((wake_reg == WK_SEND) & ~wake_end);
      end
   end

   // =========================================================
   // cyclic sleep receive: listen each interval, stay on 35 ms of initializer
   logic [31:0] det_cnt_reg;
   wire det_done = (det_cnt_reg == 32'(WAKE_DET_CYC - 1));
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         det_cnt_reg  <= 32'h0;
         o_rx_listen  <= 1'b0;
         o_stay_awake <= 1'b0;
      end else begin
         if (!i_wake_init_detect || !o_rx_listen) det_cnt_reg <= 32'h0;
         else if (!det_done)                      det_cnt_reg <= det_cnt_reg + 32'h1;
         // wake once per interval, keep listening while detected
         if (i_cyclic_sleep & i_sleep_interval_tick) o_rx_listen <= 1'b1;
         else if (!i_wake_init_detect & !o_stay_awake) o_rx_listen <= 1'b0;
         if (o_rx_listen & i_wake_init_detect & det_done) o_stay_awake <= 1'b1;
         else if (i_rx_done | ~i_cyclic_sleep)            o_stay_awake <= 1'b0;
      end
   end

   // =========================================================
   // receive filters and cipher outputs
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rx_accept   <= 1'b0;
         o_hop_channel <= `RMB_RST_HOP_CHAN;
         o_encrypt_en  <= 1'b0;
         o_cipher_key  <= 256'h0;
         o_iv_bytes    <= 8'h00;
      end else begin
         // accept only matching channel and vendor id
         o_rx_accept   <= i_rx_hdr_valid & (i_rx_hop_channel == hop_channel_reg) &
                          (i_rx_vendor_id == vendor_filter_id_reg);
         o_hop_channel <= hop_channel_reg;
         // nonzero key enables CBC with appended IV
         o_encrypt_en  <= (cipher_key_reg != 256'h0);
         o_cipher_key  <= cipher_key_reg;
         o_iv_bytes    <= (cipher_key_reg != 256'h0) ? `RMB_IV_BYTES : 8'h00;
      end
   end

   // =========================================================
   // assertions
   sequence s_pause_sent;
      o_host_tx_valid && o_host_tx_char == 8'h13;
   endsequence
   property p_xoff_char;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      send_xoff |=> s_pause_sent;
   endproperty
   a_xoff_char: assert property (p_xoff_char)
      else $error("pause character not sent");

   property p_cts_drop;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (at_thr && !soft_flow_enable_reg) |=> o_general_output_one_n;
   endproperty
   a_cts_drop: assert property (p_cts_drop)
      else $error("clear-to-send not dropped at threshold");

   property p_cts_soft;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      soft_flow_enable_reg |=> !o_general_output_one_n;
   endproperty
   a_cts_soft: assert property (p_cts_soft)
      else $error("clear-to-send dropped under software flow");

   property p_good_sat;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (good_packet_count_reg == 16'hFFFF && !(do_wr && hit_good))
      |=> good_packet_count_reg == 16'hFFFF;
   endproperty
   a_good_sat: assert property (p_good_sat)
      else $error("good counter left saturation");

   property p_good_inc;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_good_pkt && !(do_wr && hit_good) && good_packet_count_reg != 16'hFFFF)
      |=> good_packet_count_reg == $past(good_packet_count_reg) + 16'h0001;
   endproperty
   a_good_inc: assert property (p_good_inc)
      else $error("good counter did not count");

   property p_hop_range;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      hop_channel_reg <= 4'h9;
   endproperty
   a_hop_range: assert property (p_hop_range)
      else $error("hop channel out of range");

   property p_key_err;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (wr && hit_key && i_key_digits == 7'h00) |=> o_rsp_error && $stable(cipher_key_reg);
   endproperty
   a_key_err: assert property (p_key_err)
      else $error("empty key write not rejected");

   property p_key_noread;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (i_cmd_valid && !i_cmd_write && hit_key) |=> o_rsp_error && o_rsp_data == 16'h0000;
   endproperty
   a_key_noread: assert property (p_key_noread)
      else $error("key read not refused");

   property p_full_init;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      fs_hit |=> o_tx_full_init;
   endproperty
   a_full_init: assert property (p_full_init)
      else $error("forced sync did not request initializer");

   property p_wake_off;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      (wake_idle_time_reg == 16'hFFFF && wake_reg == WK_IDLE) |=> !o_wake_init_tx;
   endproperty
   a_wake_off: assert property (p_wake_off)
      else $error("wake-up initializer sent while disabled");

   property p_stay_awake;
      @(posedge i_sys_clk) disable iff (!i_arst_n)
      $rose(o_stay_awake) |-> $past(det_done) && $past(i_wake_init_detect);
   endproperty
   a_stay_awake: assert property (p_stay_awake)
      else $error("stayed awake without full detection");

endmodule : rmb_param_bank
`default_nettype wire

// [rmb_host_model.sv]
// host serial controller model that follows the flow characters
`timescale 1ns/1ps
`default_nettype none
module rmb_host_model (
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_arst_n,
   // flow control from the device
   input  wire logic       i_cts_n,
   input  wire logic       i_char_valid,
   input  wire logic [7:0] i_char,
   // host state
   output logic            o_may_send,
   output var logic        o_paused
);
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) o_paused <= 1'b0;
      else if (i_char_valid && i_char == 8'h13) o_paused <= 1'b1;
      else if (i_char_valid && i_char == 8'h11) o_paused <= 1'b0;
   end
   assign o_may_send = !i_cts_n && !o_paused;
endmodule : rmb_host_model
`default_nettype wire

// [rf_modem_link_param_bank_bench.sv]
// self-checking bench of the radio modem link parameter bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
   $display("FAIL %0t mismatch", $time); end end
`define WAIT(c, l) begin for (wn = 0; wn < (l) && !(c); wn++) @(negedge i_sys_clk); \
   if (wn == (l)) begin n_mismatch++; complete_run(); end end
module rf_modem_link_param_bank_bench;
   import rmb_pkg::*;
   logic i_sys_clk = 0, i_arst_n = 0, i_cmd_valid = 0, i_cmd_write = 0, i_intl_variant = 0;
   logic [7:0] i_cmd_code = 0;
   logic [15:0] i_cmd_wdata = 0, i_rx_vendor_id = 0, o_rsp_data;
   logic [255:0] i_key_wdata = 0, o_cipher_key;
   logic [6:0] i_key_digits = 0;
   logic [11:0] i_rx_fill = 0;
   logic [3:0] i_rx_hop_channel = 0, o_hop_channel;
   logic i_host_tx_ready = 1, i_tx_pkt_start = 0, i_radio_tx_busy = 0, i_stream_active = 0;
   logic i_serial_activity = 0, i_radio_activity = 0, i_rx_hdr_valid = 0, i_good_pkt = 0;
   logic i_cyclic_sleep = 0, i_sleep_interval_tick = 0, i_wake_init_detect = 0, i_rx_done = 0;
   logic o_rsp_valid, o_rsp_error, o_general_output_one_n, o_host_tx_valid, o_tx_full_init;
   logic o_wake_init_tx, o_rx_accept, o_rx_listen, o_stay_awake, o_encrypt_en;
   logic o_may_send, o_paused;
   logic [1:0] o_rsp_nbytes;
   logic [7:0] o_host_tx_char, o_iv_bytes, ch;
   int n_mismatch = 0, checked = 0, wn;
   always #25 i_sys_clk = ~i_sys_clk;
   rmb_param_bank #(.TICK_CYC(20), .WAKE_DET_CYC(10)) uut (.*);
   rmb_host_model host (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .i_cts_n(o_general_output_one_n), .i_char_valid(o_host_tx_valid),
      .i_char(o_host_tx_char), .o_may_send(o_may_send), .o_paused(o_paused));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run
   // one command, response is live when this returns
   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input logic [6:0] kd);
      @(negedge i_sys_clk);
      {i_cmd_valid, i_cmd_write, i_cmd_code, i_cmd_wdata, i_key_digits} = {1'b1, w, c, d, kd};
      @(negedge i_sys_clk);
      i_cmd_valid = 0;
   endtask : cmd
   // step past the previous character pulse before looking for the next
   task automatic wait_char;
      @(negedge i_sys_clk);
      `WAIT(o_host_tx_valid === 1'b1, 20)
      ch = o_host_tx_char;
   endtask : wait_char
   task automatic pulse_start;
      i_tx_pkt_start = 1'b1;
      @(negedge i_sys_clk);
      i_tx_pkt_start = 1'b0;
   endtask : pulse_start
   task automatic t_reset_values;
      logic [7:0] rc[7] = '{8'h03, 8'h07, 8'h0C, 8'h10, 8'h11, 8'h24, 8'h3E};
      logic [15:0] rv[7] = '{16'hFFFF, 16'h0, 16'h1, 16'h0, 16'h0, 16'h07EF, 16'h0};
      logic [1:0] rn[7] = '{2'h2, 2'h1, 2'h1, 2'h2, 2'h1, 2'h2, 2'h2};
      for (int i = 0; i < 7; i++) begin
         cmd(0, rc[i], 0, 0);
         `CHK({o_rsp_valid, o_rsp_error, o_rsp_data, o_rsp_nbytes}, {2'b10, rv[i], rn[i]})
      end
      cmd(0, 8'h3C, 0, 0);
      `CHK(o_rsp_error, 1'b1)
      $display("test reset_values done");
   endtask : t_reset_values
   task automatic t_ranges;
      logic [7:0] c[7] = '{8'h11, 8'h11, 8'h24, 8'h27, 8'h27, 8'h7E, 8'h07};
      logic [15:0] d[7] = '{16'h9, 16'hA, 16'h07F0, 16'h10, 16'h7FFF, 16'h1, 16'h2};
      logic e[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
      for (int i = 0; i < 7; i++) begin
         cmd(1, c[i], d[i], 0);
         `CHK({o_rsp_valid, o_rsp_error}, {1'b1, e[i]})
      end
      `CHK(o_hop_channel, 4'h9)
      $display("test ranges done");
   endtask : t_ranges
   task automatic t_good_count;
      cmd(1, 8'h10, 16'hFFFE, 0);
      i_good_pkt = 1;
      repeat (3) @(negedge i_sys_clk);
      i_good_pkt = 0;
      cmd(0, 8'h10, 0, 0);
      `CHK({o_rsp_data, o_rsp_nbytes}, {16'hFFFF, 2'h2})
      $display("test good_count done");
   endtask : t_good_count
   task automatic t_flow;
      cmd(1, 8'h24, 16'h4, 0);
      i_rx_fill = 12'h4;
      repeat (2) @(negedge i_sys_clk);
      `CHK(o_general_output_one_n, 1'b1)
      i_rx_fill = 12'h3;
      repeat (2) @(negedge i_sys_clk);
      `CHK(o_may_send, 1'b1)
      cmd(1, 8'h07, 16'h1, 0);
      i_rx_fill = 12'h4;
      wait_char();
      `CHK(ch, 8'h13)
      i_rx_fill = 12'h0;
      wait_char();
      `CHK(ch, 8'h11)
      $display("test flow done");
   endtask : t_flow
   task automatic t_key;
      i_key_wdata = 256'h1;
      cmd(1, 8'h3C, 0, 7'h40);
      `CHK(o_rsp_error, 1'b0)
      @(negedge i_sys_clk);
      `CHK({o_encrypt_en, o_iv_bytes}, {1'b1, 8'h10})
      `CHK(o_cipher_key, 256'h1)
      cmd(1, 8'h3C, 0, 7'h05);
      `CHK(o_rsp_error, 1'b1)
      cmd(1, 8'h3C, 0, 7'h00);
      `CHK(o_rsp_error, 1'b1)
      i_intl_variant = 1'b1;
      cmd(1, 8'h3C, 0, 7'h40);
      `CHK(o_rsp_error, 1'b1)
      cmd(1, 8'h3C, 0, 7'h20);
      `CHK(o_rsp_error, 1'b0)
      i_intl_variant = 1'b0;
      $display("test key done");
   endtask : t_key
   task automatic t_sync;
      cmd(1, 8'h3E, 16'h2, 0);
      i_stream_active = 1'b1;
      i_radio_tx_busy = 1'b1;
      i_rx_fill = 12'h3;
      pulse_start();
      `CHK(o_tx_full_init, 1'b0)
      `WAIT(o_tx_full_init === 1'b1, 50)
      `CHK(o_tx_full_init, 1'b1)
      i_stream_active = 1'b0;
      pulse_start();
      `CHK(o_tx_full_init, 1'b0)
      i_rx_fill = 12'h0;
      i_radio_tx_busy = 1'b0;
      @(negedge i_sys_clk);
      `CHK(o_tx_full_init, 1'b1)
      $display("test sync done");
   endtask : t_sync
   task automatic t_wake;
      // idle time far below sleep timeout
      cmd(1, 8'h03, 16'h1, 0);
      cmd(1, 8'h0C, 16'h2, 0);
      i_serial_activity = 1'b1;
      @(negedge i_sys_clk);
      i_serial_activity = 1'b0;
      pulse_start();
      `CHK(o_wake_init_tx, 1'b0)
      repeat (210) @(negedge i_sys_clk);
      pulse_start();
      `CHK(o_wake_init_tx, 1'b1)
      repeat (200) @(negedge i_sys_clk);
      `CHK(o_wake_init_tx, 1'b1)
      `WAIT(o_wake_init_tx === 1'b0, 210)
      `CHK(o_wake_init_tx, 1'b0)
      $display("test wake done");
   endtask : t_wake
   task automatic t_rx;
      i_rx_hop_channel = 4'h9;
      i_rx_vendor_id = 16'h7FFF;
      i_rx_hdr_valid = 1'b1;
      @(negedge i_sys_clk);
      `CHK(o_rx_accept, 1'b1)
      i_rx_hop_channel = 4'h8;
      @(negedge i_sys_clk);
      `CHK(o_rx_accept, 1'b0)
      i_rx_hop_channel = 4'h9;
      i_rx_vendor_id = 16'h7FFE;
      @(negedge i_sys_clk);
      `CHK(o_rx_accept, 1'b0)
      i_rx_hdr_valid = 1'b0;
      i_cyclic_sleep = 1'b1;
      i_sleep_interval_tick = 1'b1;
      @(negedge i_sys_clk);
      i_sleep_interval_tick = 1'b0;
      `CHK(o_rx_listen, 1'b1)
      i_wake_init_detect = 1'b1;
      repeat (8) @(negedge i_sys_clk);
      `CHK(o_stay_awake, 1'b0)
      repeat (2) @(negedge i_sys_clk);
      `CHK(o_stay_awake, 1'b1)
      i_wake_init_detect = 1'b0;
      i_rx_done = 1'b1;
      @(negedge i_sys_clk);
      i_rx_done = 1'b0;
      `CHK(o_stay_awake, 1'b0)
      i_cyclic_sleep = 1'b0;
      cmd(0, 8'h10, 0, 0);
      `CHK(o_rsp_data, 16'hFFFF)
      $display("test rx done");
   endtask : t_rx
   initial begin
      repeat (4) @(negedge i_sys_clk);
      i_arst_n = 1;
      t_reset_values();
      t_ranges();
      t_good_count();
      t_flow();
      t_key();
      t_sync();
      t_wake();
      t_rx();
      complete_run();
   end
endmodule : rf_modem_link_param_bank_bench
`default_nettype wire
